// *** logic/acm_pkg.sv ***
// Package with constants and types for the channel map and result word block.
package acm_pkg;
	localparam int DATA_W      = 18;
	localparam int WORD_W      = 24;
	localparam int TAG_W       = 3;
	localparam int CNT_W       = 5;
	localparam logic [CNT_W-1:0] RD_BITS = 5'h18;
	localparam logic [CNT_W-1:0] WR_BITS = 5'h08;
	// Result word field positions.
	localparam int RSV_POS     = 5;
	localparam int AUX_LO_POS  = 3;
	localparam int TAG_LO_POS  = 0;
	localparam int DATA_LO_POS = 6;
	// Transfer-function register layout: gain, unipolar, offset code.
	localparam int TF_W        = 8;
	localparam int GAIN_LO     = 5;
	localparam int UNI_POS     = 4;
	localparam int SIGN_POS    = 3;
	localparam int MAG_W       = 3;
	// Transfer-function register numbers.
	localparam logic [1:0] TF1 = 2'h1;
	localparam logic [1:0] TF2 = 2'h2;
	localparam logic [1:0] TF3 = 2'h3;
	// Channel tags.
	localparam logic [TAG_W-1:0] TAG_PSEUDO0 = 3'h0;
	localparam logic [TAG_W-1:0] TAG_DIFF0   = 3'h4;
	localparam logic [TAG_W-1:0] TAG_AIN5    = 3'h6;
	localparam logic [TAG_W-1:0] TAG_CAL     = 3'h7;
	// Input multiplexer codes.
	localparam logic [3:0] MUX_PSEUDO0 = 4'h0;
	localparam logic [3:0] MUX_DIFF0   = 4'h5;
	localparam logic [3:0] MUX_OFFSET_CALIBRATION_PAIR  = 4'h8;
	localparam logic [3:0] MUX_GAIN_CALIBRATION_PAIR = 4'h9;
	// Scan sequence lengths.
	localparam logic [2:0] SCAN_PSEUDO_N = 3'h5;
	localparam logic [2:0] SCAN_FULLY_DIFFERENTIAL_SELECT_N   = 3'h3;
	localparam logic [2:0] SCAN_CAL_N    = 3'h2;
	// Offset-binary limits and bias.
	localparam logic [DATA_W-1:0] CODE_MIN = 18'h00000;
	localparam logic [DATA_W-1:0] CODE_MAX = 18'h3FFFF;
	localparam logic [DATA_W-1:0] CODE_MID = 18'h20000;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_READ  = 3'h2,
		ST_WRITE = 3'h4
	} acm_state_t;
endpackage : acm_pkg

// *** logic/acm_core.sv ***
// Channel to transfer-function mapping and serial result word of the ADC.
//
// Functional notes
// - Offset DAC steps, doubled unipolar, zero disconnects.
// - Non-scan normal mode select to register map.
// - Scanning uses fixed register per channel.
// - Offset calibration pair mapping and scan append.
// - Gain calibration pair mapping and scan append.
// - Result register read-only; writes change nothing.
// - Write access takes eight bits, then idle.
// - Word MSB first: data, reserved, aux, tag.
// - Eighteen-bit offset-binary conversion value.
// - Out-of-range input saturates, never wraps.
// - Reserved bit after data always zero.
// - Aux inputs captured on first falling edge.
// - Tag codes: pseudo, differential, calibration.
// - Offset code top bit sign, rest magnitude.
// - Active control change drops ready, restarts.
module acm_core
	import acm_pkg::*;
#(
	parameter int RAW_W = 20
) (
	input  wire logic                   clk_i,
	input  wire logic                   rstn_i,
	input  wire logic                   sclk_i,
	input  wire logic                   din_i,
	input  wire logic                   aux_input_bit_high_i,
	input  wire logic                   aux_input_bit_low_i,
	input  wire logic                   rd_start_i,
	input  wire logic                   wr_start_i,
	input  wire logic                   scan_i,
	input  wire logic                   fully_differential_select_i,
	input  wire logic                   cal_mode_high_i,
	input  wire logic                   cal_mode_low_i,
	input  wire logic                   channel_select_high_i,
	input  wire logic                   channel_select_low_i,
	input  wire logic [3*acm_pkg::TF_W-1:0] tf_regs_i,
	input  wire logic                   conv_valid_i,
	input  wire logic signed [RAW_W-1:0] conv_raw_i,
	output logic                        dout_o,
	output logic                        access_done_o,
	output logic                        data_ready_o,
	output logic                        restart_o,
	output logic [1:0]                  tf_select_o,
	output logic [3:0]                  mux_code_o,
	output logic [acm_pkg::TAG_W-1:0]   source_channel_tag_o,
	output logic [2:0]                  pga_gain_o,
	output logic                        unipolar_o,
	output logic                        dac_connect_o,
	output logic                        dac_negative_o,
	output logic [3:0]                  dac_steps_o
);
	import acm_pkg::*;

	if (RAW_W < DATA_W) begin : g_chk
		$error("RAW_W must be at least the conversion width");
	end

	localparam logic signed [RAW_W-1:0] RAW_MAX = RAW_W'(CODE_MID - 18'h1);
	localparam logic signed [RAW_W-1:0] RAW_MIN = -RAW_W'(CODE_MID);

	typedef struct packed {
		acm_state_t          st;
		logic [2:0]          sclk_ff;
		logic [2:0]          din_ff;
		logic [2:0]          auxh_ff;
		logic [2:0]          auxl_ff;
		logic                sclk_lvl;
		logic                first_fall;
		logic [CNT_W-1:0]    bitcnt;
		logic [WORD_W-1:0]   shreg;
		logic                dout;
		logic                done;
		logic [DATA_W-1:0]   result;
		logic [TAG_W-1:0]    res_tag;
		logic                drdy;
		logic                restart;
		logic [2:0]          scan_idx;
		logic [1:0]          tf_sel;
		logic [TAG_W-1:0]    tag;
		logic [3:0]          mux;
		logic [TF_W-1:0]     act_tf;
		logic [13:0]         ctl;
		logic [1:0]          ctl_sel;
	} acm_regs_t;

	acm_regs_t r_reg;
	acm_regs_t r_next;
	logic      ctl_chg;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic              rise;
		logic              fall;
		logic              calm;
		logic [2:0]        nsig;
		logic [2:0]        nseq;
		logic [1:0]        sel;
		logic [TF_W-1:0]   tfb;
		logic [DATA_W-1:0] code;
		logic [WORD_W-1:0] sh;
		logic              cvt;
		rise = 1'b0;
		fall = 1'b0;
		sh   = '0;
		tfb  = '0;
		code = '0;
		cvt  = 1'b0;
		ctl_chg = 1'b0;
		r_next = r_reg;
		r_next.done    = 1'b0;
		r_next.restart = 1'b0;
		r_next.sclk_ff = {r_reg.sclk_ff[1:0], sclk_i};
		r_next.din_ff  = {r_reg.din_ff[1:0], din_i};
		r_next.auxh_ff = {r_reg.auxh_ff[1:0], aux_input_bit_high_i};
		r_next.auxl_ff = {r_reg.auxl_ff[1:0], aux_input_bit_low_i};
		// A pin change counts only once the last two stages agree.
		if (r_reg.sclk_ff[1] == r_reg.sclk_ff[2]
			&& r_reg.sclk_ff[2] != r_reg.sclk_lvl) begin
			r_next.sclk_lvl = r_reg.sclk_ff[2];
			rise = r_reg.sclk_ff[2];
			fall = !r_reg.sclk_ff[2];
		end

		// Channel and transfer-function selection.
		sel  = {channel_select_high_i, channel_select_low_i};
		// Reserved mode 11 falls back to normal mode.
		calm = cal_mode_high_i ^ cal_mode_low_i;
		nsig = fully_differential_select_i ? SCAN_FULLY_DIFFERENTIAL_SELECT_N : SCAN_PSEUDO_N;
		nseq = calm ? nsig + SCAN_CAL_N : nsig;
		if (scan_i) begin
			if (r_reg.scan_idx >= nsig) begin
				r_next.tf_sel = TF3;
				r_next.tag    = TAG_CAL;
				// Offset pair always precedes the gain pair.
				r_next.mux = (r_reg.scan_idx == nsig) ? MUX_OFFSET_CALIBRATION_PAIR
					: MUX_GAIN_CALIBRATION_PAIR;
			end else if (fully_differential_select_i) begin
				r_next.tf_sel = 2'(r_reg.scan_idx) + TF1;
				r_next.tag    = TAG_DIFF0 + r_reg.scan_idx;
				r_next.mux    = MUX_DIFF0 + 4'(r_reg.scan_idx);
			end else begin
				r_next.tf_sel = r_reg.scan_idx[2] ? TF3
					: (r_reg.scan_idx[1] ? TF2 : TF1);
				r_next.tag = r_reg.scan_idx[2] ? TAG_AIN5
					: TAG_PSEUDO0 + r_reg.scan_idx;
				r_next.mux = MUX_PSEUDO0 + 4'(r_reg.scan_idx);
			end
		end else begin
			if (fully_differential_select_i) begin
				// Select 11 is forbidden to the host; it lands on TF3.
				r_next.tf_sel = (sel == 2'h3) ? TF3 : sel + TF1;
				r_next.tag = (sel == 2'h3) ? TAG_AIN5
					: TAG_DIFF0 + {1'b0, sel};
				r_next.mux = MUX_DIFF0 + 4'(sel);
			end else begin
				r_next.tf_sel = sel[1] ? TF2 : TF1;
				r_next.tag    = TAG_PSEUDO0 + {1'b0, sel};
				r_next.mux    = MUX_PSEUDO0 + 4'(sel);
			end
			if (calm) begin
				r_next.tag = TAG_CAL;
				r_next.mux = cal_mode_low_i ? MUX_OFFSET_CALIBRATION_PAIR
					: MUX_GAIN_CALIBRATION_PAIR;
			end
		end
		unique case (r_reg.tf_sel)
			TF2:     tfb = tf_regs_i[TF_W +: TF_W];
			TF3:     tfb = tf_regs_i[2*TF_W +: TF_W];
			default: tfb = tf_regs_i[0 +: TF_W];
		endcase
		r_next.act_tf = tfb;

		// Any change in the controls of the channel in use restarts it.
		r_next.ctl = {cal_mode_high_i, cal_mode_low_i, scan_i,
			fully_differential_select_i, sel, tfb};
		r_next.ctl_sel = r_reg.tf_sel;
		// A byte that differs only because the scan moved on to another
		// register is no user change; restarting there would stall the scan.
		ctl_chg = ((r_next.ctl >> TF_W) != (r_reg.ctl >> TF_W))
			|| (r_reg.tf_sel == r_reg.ctl_sel
			&& tfb != r_reg.ctl[TF_W-1:0]);
		if (ctl_chg) begin
			r_next.restart  = 1'b1;
			r_next.drdy     = 1'b0;
			r_next.scan_idx = '0;
		end else if (conv_valid_i) begin
			if (conv_raw_i > RAW_MAX) begin
				code = CODE_MAX;
			end else if (conv_raw_i < RAW_MIN) begin
				code = CODE_MIN;
			end else begin
				code = DATA_W'(conv_raw_i) ^ CODE_MID;
			end
			r_next.result  = code;
			r_next.res_tag = r_reg.tag;
			r_next.drdy    = 1'b1;
			cvt            = 1'b1;
			if (scan_i) begin
				r_next.scan_idx = (r_reg.scan_idx + 3'h1 >= nseq) ? 3'h0
					: r_reg.scan_idx + 3'h1;
			end
		end

		// Serial access to the result register.
		unique case (r_reg.st)
			ST_IDLE: begin
				r_next.bitcnt = '0;
				if (rd_start_i) begin
					sh = {r_reg.result, 1'b0, 2'b00, r_reg.res_tag};
					r_next.shreg      = sh;
					r_next.dout       = sh[WORD_W-1];
					r_next.first_fall = 1'b1;
					r_next.st         = ST_READ;
				end else if (wr_start_i) begin
					r_next.st = ST_WRITE;
				end
			end
			ST_READ: begin
				if (fall) begin
					sh = r_reg.shreg;
					// The first fall only latches aux: the host samples on
					// rises, so shifting here would lose the top bit.
					if (r_reg.first_fall) begin
						sh[AUX_LO_POS +: 2] = {r_reg.auxh_ff[2],
							r_reg.auxl_ff[2]};
					end else begin
						sh = {sh[WORD_W-2:0], 1'b0};
					end
					r_next.shreg      = sh;
					r_next.dout       = sh[WORD_W-1];
					r_next.first_fall = 1'b0;
				end
				if (rise) begin
					r_next.bitcnt = r_reg.bitcnt + 5'h1;
					if (r_reg.bitcnt == RD_BITS - 5'h1) begin
						r_next.st   = ST_IDLE;
						r_next.done = 1'b1;
						// A conversion landing in this cycle keeps ready set.
						r_next.drdy = cvt;
					end
				end
			end
			ST_WRITE: begin
				// Shifted-in bits are discarded, so the result stays put.
				if (rise) begin
					r_next.bitcnt = r_reg.bitcnt + 5'h1;
					if (r_reg.bitcnt == WR_BITS - 5'h1) begin
						r_next.st   = ST_IDLE;
						r_next.done = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			r_reg          <= '0;
			r_reg.st       <= ST_IDLE;
			r_reg.tf_sel   <= TF1;
			r_reg.sclk_ff  <= 3'h7;
			r_reg.sclk_lvl <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign dout_o               = r_reg.dout;
	assign access_done_o        = r_reg.done;
	assign data_ready_o         = r_reg.drdy;
	assign restart_o            = r_reg.restart;
	assign tf_select_o          = r_reg.tf_sel;
	assign mux_code_o           = r_reg.mux;
	assign source_channel_tag_o = r_reg.tag;
	assign pga_gain_o           = r_reg.act_tf[GAIN_LO +: 3];
	assign unipolar_o           = r_reg.act_tf[UNI_POS];
	// One step is a twelfth of full scale; unipolar doubles each step.
	assign dac_connect_o  = |r_reg.act_tf[0 +: MAG_W];
	assign dac_negative_o = r_reg.act_tf[SIGN_POS];
	assign dac_steps_o    = {1'b0, r_reg.act_tf[0 +: MAG_W]}
		<< r_reg.act_tf[UNI_POS];

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	a_write_frozen: assert property ((r_reg.st == ST_WRITE && !conv_valid_i)
		|=> $stable(r_reg.result)) else $error("write changed result");
	a_write_eight: assert property ((r_reg.st == ST_WRITE
		&& r_reg.bitcnt == WR_BITS - 5'h1 && r_next.bitcnt == WR_BITS)
		|=> r_reg.st == ST_IDLE && access_done_o)
		else $error("write did not end after eight bits");
	a_rsv_zero: assert property ((r_reg.st == ST_IDLE && rd_start_i)
		|=> r_reg.shreg[RSV_POS] == 1'b0
		&& dout_o == $past(r_reg.result[DATA_W-1]))
		else $error("word load wrong");
	a_tf_normal: assert property ((!scan_i && !cal_mode_high_i
		&& !cal_mode_low_i && !fully_differential_select_i)
		|=> tf_select_o == ($past(channel_select_high_i) ? TF2 : TF1))
		else $error("normal map wrong");
	a_scan_cal: assert property ((r_reg.ctl[11] && (mux_code_o == MUX_OFFSET_CALIBRATION_PAIR
		|| mux_code_o == MUX_GAIN_CALIBRATION_PAIR)) |-> tf_select_o == TF3
		&& source_channel_tag_o == TAG_CAL)
		else $error("scan calibration map wrong");
	a_sat_high: assert property ((conv_valid_i && conv_raw_i > RAW_MAX
		&& !ctl_chg) |=> r_reg.result == CODE_MAX)
		else $error("no saturation");
	a_restart_drop: assert property (ctl_chg
		|=> restart_o && !data_ready_o) else $error("no restart");
	a_dac_off: assert property ((r_reg.act_tf[0 +: MAG_W] == 3'h0)
		|-> !dac_connect_o && dac_steps_o == 4'h0)
		else $error("zero code must disconnect");

	c_read_done: cover property (r_reg.st == ST_READ ##1 access_done_o);
	c_write_done: cover property (r_reg.st == ST_WRITE ##1 access_done_o);
	c_scan_cal: cover property (mux_code_o == MUX_OFFSET_CALIBRATION_PAIR
		##[1:1000] mux_code_o == MUX_GAIN_CALIBRATION_PAIR);
endmodule : acm_core

// *** testbench/acm_host.sv ***
// Host model that clocks the serial port for result reads and writes.
module acm_host (
	input  wire logic clk_i,
	input  wire logic dout_i,
	output logic      sclk_o,
	output logic      din_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic busy;
	initial begin
		sclk_o = 1'b1;
		din_o  = 1'b0;
		busy   = 1'b0;
	end
	// Between frames the data line toggles, so a stale level is never trusted.
	always @(posedge clk_i) begin
		#1;
		if (!busy)
			din_o = ~din_o;
	end
	// Clock idles high; data changes after the fall, sampled before the rise.
	task automatic clock_bits(input int n, input logic [23:0] tx,
		output logic [23:0] rx);
		rx = '0;
		busy = 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk_i);
			#1;
			sclk_o = 1'b0;
			din_o = tx[i];
			repeat (6) @(posedge clk_i);
			#1;
			rx[i] = dout_i;
			sclk_o = 1'b1;
			repeat (5) @(posedge clk_i);
		end
		busy = 1'b0;
	endtask : clock_bits
endmodule : acm_host

// *** testbench/acm_core_tb.sv ***
// Self-checking bench for the channel map and result word block.
module acm_core_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import acm_pkg::*;
	logic              clk_i = 1'b0;
	logic              rstn_i, sclk, din, aux_h, aux_l, rd_st, wr_st, cv;
	logic              scan, fully_differential_select, m_hi, m_lo, s_hi, s_lo;
	logic              dout, done, ready, restart, uni, dac_con, dac_neg;
	logic [23:0]       tf_regs, rx;
	logic signed [19:0] raw;
	logic [1:0]        tf_sel;
	logic [3:0]        mux, steps;
	logic [2:0]        tag, gain;
	int err_total = 0, cmp_count = 0, seed = 32'h05e3cd37;
	int rs_cnt = 0, dn_cnt = 0, pv = 0, r0, d0, r, n, e_tf, e_mx, e_tg;
	int lim[6] = '{131071, 131072, -131072, -131073, 0, -524288};

	acm_core dut (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .din_i(din),
		.aux_input_bit_high_i(aux_h), .aux_input_bit_low_i(aux_l),
		.rd_start_i(rd_st), .wr_start_i(wr_st), .scan_i(scan),
		.fully_differential_select_i(fully_differential_select), .cal_mode_high_i(m_hi),
		.cal_mode_low_i(m_lo), .channel_select_high_i(s_hi),
		.channel_select_low_i(s_lo), .tf_regs_i(tf_regs), .conv_valid_i(cv),
		.conv_raw_i(raw), .dout_o(dout), .access_done_o(done),
		.data_ready_o(ready), .restart_o(restart), .tf_select_o(tf_sel),
		.mux_code_o(mux), .source_channel_tag_o(tag), .pga_gain_o(gain),
		.unipolar_o(uni), .dac_connect_o(dac_con), .dac_negative_o(dac_neg),
		.dac_steps_o(steps));
	acm_host host (.clk_i(clk_i), .dout_i(dout), .sclk_o(sclk), .din_o(din));

	always #5 clk_i = ~clk_i;
	always @(negedge clk_i) begin
		if (restart === 1'b1)
			rs_cnt++;
		if (done === 1'b1)
			dn_cnt++;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("errors %0d comparisons %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h wanted %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : tick
	function automatic logic [17:0] sat(input int v);
		if (v > 131071)
			return 18'h3FFFF;
		if (v < -131072)
			return 18'h00000;
		return 18'(v + 131072);
	endfunction : sat
	// Reference map of channel, register and tag from the mode tables.
	function automatic void emap(input int sc, md, df, sl, ix,
		output int tf, mx, tg);
		int p;
		p = sc ? ix : sl;
		if (sc != 0 && p >= (df ? 3 : 5)) begin
			tf = 3;
			mx = 8 + p - (df ? 3 : 5);
			tg = 7;
		end else begin
			tf = df ? p + 1 : p / 2 + 1;
			mx = df ? 5 + p : p;
			tg = df ? 4 + p : (p == 4 ? 6 : p);
			if (sc == 0 && md != 0) begin
				mx = 7 + md;
				tg = 7;
			end
		end
	endfunction : emap
	task automatic set_ctl(input int sc, md, df, sl);
		scan = sc[0];
		{m_hi, m_lo} = 2'(md);
		fully_differential_select = df[0];
		{s_hi, s_lo} = 2'(sl);
		tick(6);
	endtask : set_ctl
	task automatic conv(input int v);
		raw = 20'(v);
		cv = 1'b1;
		tick(1);
		cv = 1'b0;
		tick(3);
	endtask : conv
	task automatic wait_done(input int base);
		for (int k = 0; k < 20 && dn_cnt == base; k++)
			tick(1);
		if (dn_cnt == base) begin
			err_total++;
			$display("unexpected at %0t: access never ended", $time);
			finish_test();
		end
	endtask : wait_done
	task automatic read_word(input int v, input int tg);
		{aux_h, aux_l} = 2'($random(seed));
		rd_st = 1'b1;
		tick(1);
		rd_st = 1'b0;
		d0 = dn_cnt;
		host.clock_bits(24, 24'h000000, rx);
		wait_done(d0);
		chk(rx, {sat(v), 1'b0, aux_h, aux_l, 3'(tg)});
	endtask : read_word
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rstn_i, aux_h, aux_l, rd_st, wr_st, cv} = '0;
		{scan, fully_differential_select, m_hi, m_lo, s_hi, s_lo} = '0;
		raw = '0;
		tf_regs = 24'($random(seed));
		repeat (6) @(posedge clk_i);
		#1;
		rstn_i = 1'b1;
		tick(4);
		chk(24'({tf_sel, mux, tag}), 24'h000080);
		for (int md = 0; md < 3; md++)
			for (int df = 0; df < 2; df++)
				for (int sl = 0; sl < 4; sl++) begin
					if (df == 1 && sl == 3)
						continue;
					r0 = rs_cnt;
					set_ctl(0, md, df, sl);
					chk(24'(rs_cnt > r0), 24'(md * 8 + df * 4 + sl != pv));
					chk(24'(ready), 24'h000000);
					pv = md * 8 + df * 4 + sl;
					emap(0, md, df, sl, 0, e_tf, e_mx, e_tg);
					chk(24'({tf_sel, mux, tag}), 24'({2'(e_tf), 4'(e_mx), 3'(e_tg)}));
					rx[7:0] = tf_regs[(e_tf - 1) * 8 +: 8];
					chk(24'({gain, uni, dac_con, steps}), 24'({rx[7:4], rx[2:0] != 3'h0,
						rx[4] ? {rx[2:0], 1'b0} : {1'b0, rx[2:0]}}));
					if (rx[2:0] != 3'h0)
						chk(24'(dac_neg), 24'(rx[3]));
					r = pv < 6 ? lim[pv % 6] : $random(seed) % 524288;
					conv(r);
					read_word(r, e_tg);
					r = $random(seed) % 524288;
					conv(r);
					// Flip a byte that the current channel does not use.
					tf_regs[(e_tf % 3) * 8 +: 8] = ~tf_regs[(e_tf % 3) * 8 +: 8];
					r0 = rs_cnt;
					tick(6);
					chk(24'({rs_cnt == r0, ready}), 24'h000003);
				end
		wr_st = 1'b1;
		tick(1);
		wr_st = 1'b0;
		d0 = dn_cnt;
		host.clock_bits(8, 24'($random(seed)), rx);
		wait_done(d0);
		chk(24'(ready), 24'h000001);
		read_word(r, e_tg);
		for (int md = 0; md < 3; md++)
			for (int df = 0; df < 2; df++) begin
				set_ctl(1, md, df, {$random(seed)} % (df ? 3 : 4));
				n = (df ? 3 : 5) + (md != 0 ? 2 : 0);
				for (int k = 0; k <= n; k++) begin
					emap(1, md, df, 0, k % n, e_tf, e_mx, e_tg);
					chk(24'({tf_sel, mux, tag}), 24'({2'(e_tf), 4'(e_mx), 3'(e_tg)}));
					r = $random(seed) % 524288;
					conv(r);
					if (k == n - 1)
						read_word(r, e_tg);
				end
			end
		finish_test();
	end
endmodule : acm_core_tb
